/* hdl/lrec_cfg.svh */
// Behaviour
// - send own link reset within 5 ms
// - disable port within 5 ms of both resets
// - enable port within 5 ms after disable
// - failed recovery first clears usable flag; a cfgOperational set in that cycle keeps it set
// - failed recovery forces privileged mode, drops traffic
// - failed recovery raises alert with exit code
// - failed recovery ends by restarting port
// - code violation while sending aborts, starts recovery
// - discard accepted buffers, resend only unreceived
// - screen only frames received without link error
// - unknown message code check comes first
// - unknown code: no reply, alert instead
// - ready on flag within 5 ms, else timeout
// - outstanding = transmit minus retry pointer mod N
`ifndef LREC_CFG_SVH
`define LREC_CFG_SVH

`define LR_DEADLINE_MS 5
`define LR_CLK_KHZ 250000
`define LR_TMR_W 21
`define LR_PTR_W 2
`define LR_SEQ_W 2
`define LR_CODE_W 8
`define LR_MM_CODE_MAX 8'h3F
`define LR_PTR_ONE 2'h1
`define LR_PTR_ZERO 2'h0
`define LR_TMR_ZERO 21'h000000
`define LR_TMR_ONE 21'h000001
`define LR_EXIT_OK 8'h00
`define LR_EXIT_LR_FAILED 8'h11
`define LR_EXIT_BAD_RETRY 8'h12
`define LR_EXIT_TO_DIS 8'h13
`define LR_EXIT_TO_READY 8'h14
`define LR_ALERT_UNKNOWN_MM 8'h21

`endif

/* hdl/lrec_pkg.sv */
`include "lrec_cfg.svh"

package lrec_pkg;

  typedef logic [`LR_PTR_W-1:0] lrec_ptr_t;
  typedef logic [`LR_CODE_W-1:0] lrec_code_t;

  // gray steps along the recovery path and along the exit sequence
  typedef enum logic [3:0] {
    LR_IDLE = 4'h0,
    LR_CHECK = 4'h1,
    LR_LRESET = 4'h3,
    LR_RETIRE = 4'h2,
    LR_WAITDIS = 4'h6,
    LR_ENABLE = 4'h7,
    LR_EXFLAG = 4'h5,
    LR_EXPRIV = 4'h4,
    LR_EXALERT = 4'hC,
    LR_EXRESTART = 4'hD
  } lrec_state_t;

endpackage : lrec_pkg

/* hdl/lrec_tmr_if.sv */
`timescale 1ns/10ps

interface lrec_tmr_if;
  logic start;
  logic expired;
  modport ctl (output start, input expired);
  modport tmr (input start, output expired);
endinterface : lrec_tmr_if

/* hdl/lrec_ms_timer.sv */
`timescale 1ns/10ps
`include "lrec_cfg.svh"

module lrec_ms_timer
  import lrec_pkg::*;
#(
  parameter logic [`LR_TMR_W-1:0] LIMIT = `LR_TMR_ONE
) (
  // clock and reset
  input wire logic mclk,
  input wire logic rst_b,
  // control from the sequencer
  lrec_tmr_if.tmr tmrIf
);

  logic [`LR_TMR_W-1:0] cnt_r;
  logic running_r;
  logic expired_r;

  // counter cleared on every start so each interval is measured alone
  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      cnt_r <= `LR_TMR_ZERO;
      running_r <= 1'b0;
    end else if (tmrIf.start) begin
      cnt_r <= `LR_TMR_ZERO;
      running_r <= 1'b1;
    end else if (running_r) begin
      cnt_r <= cnt_r + `LR_TMR_ONE;
      running_r <= (cnt_r != LIMIT - `LR_TMR_ONE);
    end
  end

  // single-cycle expiry when the last counted cycle passes
  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      expired_r <= 1'b0;
    end else begin
      expired_r <= running_r && !tmrIf.start &&
                   (cnt_r == LIMIT - `LR_TMR_ONE);
    end
  end

  assign tmrIf.expired = expired_r;

endmodule : lrec_ms_timer

/* hdl/lrec_exit_ctrl.sv */
`timescale 1ns/10ps
`include "lrec_cfg.svh"

module lrec_exit_ctrl
  import lrec_pkg::*;
#(
  parameter int DEADLINE_CYC = `LR_DEADLINE_MS * `LR_CLK_KHZ
) (
  // clock and reset
  input wire logic mclk,
  input wire logic rst_b,
  // link events from the receive and transmit logic
  input wire logic txBusy,
  input wire logic codeViol,
  input wire logic recoverReq,
  input wire logic linkResetRx,
  input wire logic linkResetTxDone,
  input wire logic disableCharRx,
  input wire logic flagRx,
  // transmit buffer bookkeeping
  input wire logic frameSent,
  input wire logic ackRx,
  input wire logic [`LR_SEQ_W-1:0] txFrameSequence,
  input wire logic [`LR_SEQ_W-1:0] remoteRxSequence,
  // configuration
  input wire logic cfgOperational,
  input wire logic cfgNormalMode,
  // received management messages
  input wire logic mmValid,
  input wire logic mmLinkErr,
  input wire logic [`LR_CODE_W-1:0] mmCode,
  // link control outputs
  output logic linkResetSend,
  output logic txAbort,
  output logic checkState,
  output logic portDisabled,
  output logic portEnabled,
  output logic portReady,
  output logic portRestart,
  // port flags
  output logic operational,
  output logic privilegedMode,
  // buffer outputs
  output lrec_ptr_t txBufferPointer,
  output lrec_ptr_t txRetryPointer,
  output lrec_ptr_t outstanding,
  output logic bufDiscard,
  // alert and message outputs
  output logic alertValid,
  output lrec_code_t alertCode,
  output lrec_code_t lastExitCode,
  output logic mmAccept
);

  lrec_state_t state_r, stateNxt;
  lrec_code_t exitPend_r, exitNxt;
  lrec_ptr_t txPtr_r, retryPtr_r, qNow, pNow;
  logic gotLrRx_r, gotLrTx_r, retryBad, mmPend_r;
  logic linkResetSend_r, txAbort_r, checkState_r, portDisabled_r;
  logic portEnabled_r, portReady_r, portRestart_r, operational_r;
  logic privMode_r, outstandingQ_r, bufDiscard_r, alertValid_r;
  lrec_ptr_t outstanding_r;
  lrec_code_t alertCode_r, lastExit_r;
  logic mmAccept_r;

  lrec_tmr_if tmrIf ();

  lrec_ms_timer #(
    .LIMIT(`LR_TMR_W'(DEADLINE_CYC))
  ) u_timer (
    .mclk(mclk),
    .rst_b(rst_b),
    .tmrIf(tmrIf.tmr)
  );

  // modular distance between two cyclic pointers
  function automatic lrec_ptr_t modDiff(input lrec_ptr_t a,
                                        input lrec_ptr_t b);
    modDiff = a - b;
  endfunction : modDiff

  function automatic logic isKnownCode(input lrec_code_t c);
    isKnownCode = (c <= `LR_MM_CODE_MAX);
  endfunction : isKnownCode

  assign qNow = modDiff(txPtr_r, retryPtr_r);
  assign pNow = modDiff(txFrameSequence, remoteRxSequence);
  assign retryBad = (qNow > `LR_PTR_ONE) || (pNow > qNow);

  // recovery sequencer: next state and pending exit code
  always_comb begin
    stateNxt = state_r;
    exitNxt = exitPend_r;
    case (state_r)
      LR_IDLE: begin
        if ((codeViol && txBusy) || recoverReq) begin
          stateNxt = LR_CHECK;
        end
      end
      LR_CHECK: begin
        if (!txBusy) begin
          stateNxt = LR_LRESET;
        end
      end
      LR_LRESET: begin
        if (gotLrRx_r && gotLrTx_r) begin
          if (retryBad) begin
            stateNxt = LR_EXFLAG;
            exitNxt = `LR_EXIT_BAD_RETRY;
          end else begin
            stateNxt = LR_RETIRE;
          end
        end else if (tmrIf.expired) begin
          stateNxt = LR_EXFLAG;
          exitNxt = `LR_EXIT_LR_FAILED;
        end
      end
      LR_RETIRE: begin
        if (retryPtr_r == txPtr_r) begin
          stateNxt = LR_WAITDIS;
        end
      end
      LR_WAITDIS: begin
        if (disableCharRx) begin
          stateNxt = LR_ENABLE;
        end else if (tmrIf.expired) begin
          stateNxt = LR_EXFLAG;
          exitNxt = `LR_EXIT_TO_DIS;
        end
      end
      LR_ENABLE: begin
        if (flagRx) begin
          stateNxt = LR_IDLE;
          exitNxt = `LR_EXIT_OK;
        end else if (tmrIf.expired) begin
          stateNxt = LR_EXFLAG;
          exitNxt = `LR_EXIT_TO_READY;
        end
      end
      LR_EXFLAG: stateNxt = LR_EXPRIV;
      LR_EXPRIV: stateNxt = LR_EXALERT;
      LR_EXALERT: stateNxt = LR_EXRESTART;
      LR_EXRESTART: stateNxt = LR_IDLE;
      default: stateNxt = LR_IDLE;
    endcase
  end

  // a fresh deadline for every timed stage
  assign tmrIf.start = (stateNxt != state_r) &&
                       ((stateNxt == LR_LRESET) ||
                        (stateNxt == LR_WAITDIS) ||
                        (stateNxt == LR_ENABLE));

  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      state_r <= LR_IDLE;
      exitPend_r <= `LR_EXIT_OK;
    end else begin
      state_r <= stateNxt;
      exitPend_r <= exitNxt;
    end
  end

  // reset exchange flags, set wins over the idle clear
  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      gotLrRx_r <= 1'b0;
      gotLrTx_r <= 1'b0;
    end else begin
      if (linkResetRx && (state_r == LR_CHECK || state_r == LR_LRESET)) begin
        gotLrRx_r <= 1'b1;
      end else if (state_r == LR_IDLE) begin
        gotLrRx_r <= 1'b0;
      end
      if (linkResetTxDone && state_r == LR_LRESET) begin
        gotLrTx_r <= 1'b1;
      end else if (state_r == LR_IDLE) begin
        gotLrTx_r <= 1'b0;
      end
    end
  end

  // link control: request our reset at once, well inside the deadline
  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      linkResetSend_r <= 1'b0;
      txAbort_r <= 1'b0;
      checkState_r <= 1'b0;
      portDisabled_r <= 1'b0;
      portEnabled_r <= 1'b0;
      portRestart_r <= 1'b0;
    end else begin
      linkResetSend_r <= (stateNxt == LR_LRESET) && !gotLrTx_r &&
                         !linkResetTxDone;
      txAbort_r <= (state_r == LR_IDLE) && codeViol && txBusy;
      checkState_r <= (stateNxt == LR_CHECK);
      portDisabled_r <= (stateNxt == LR_WAITDIS);
      portEnabled_r <= (stateNxt == LR_ENABLE);
      portRestart_r <= (state_r == LR_EXRESTART);
    end
  end

  // ready drops for the whole recovery and returns only on success
  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      portReady_r <= 1'b1;
    end else if (state_r == LR_ENABLE && flagRx) begin
      portReady_r <= 1'b1;
    end else if (stateNxt == LR_CHECK) begin
      portReady_r <= 1'b0;
    end
  end

  // usable flag and privileged mode; config set of the flag wins over the failure clear, hardware set of the mode wins over config clear
  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      operational_r <= 1'b0;
      privMode_r <= 1'b0;
    end else begin
      if (cfgOperational) begin
        operational_r <= 1'b1;
      end else if (state_r == LR_EXFLAG) begin
        operational_r <= 1'b0;
      end
      if (state_r == LR_EXPRIV) begin
        privMode_r <= 1'b1;
      end else if (cfgNormalMode) begin
        privMode_r <= 1'b0;
      end
    end
  end

  // buffer pointers; on recovery the transmit pointer steps back by
  // the frames the peer never saw and the rest are retired
  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      txPtr_r <= `LR_PTR_ZERO;
      retryPtr_r <= `LR_PTR_ZERO;
      bufDiscard_r <= 1'b0;
      outstanding_r <= `LR_PTR_ZERO;
    end else begin
      bufDiscard_r <= 1'b0;
      outstanding_r <= qNow;
      if (state_r == LR_LRESET && stateNxt == LR_RETIRE) begin
        txPtr_r <= txPtr_r - pNow;
      end else if (state_r == LR_IDLE && frameSent) begin
        txPtr_r <= txPtr_r + `LR_PTR_ONE;
      end
      if (state_r == LR_RETIRE && retryPtr_r != txPtr_r) begin
        retryPtr_r <= retryPtr_r + `LR_PTR_ONE;
        bufDiscard_r <= 1'b1;
      end else if (state_r == LR_IDLE && ackRx && qNow != `LR_PTR_ZERO) begin
        retryPtr_r <= retryPtr_r + `LR_PTR_ONE;
        bufDiscard_r <= 1'b1;
      end
    end
  end

  // message screen: only clean frames, unknown code tested first
  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      mmPend_r <= 1'b0;
      mmAccept_r <= 1'b0;
    end else begin
      mmAccept_r <= mmValid && !mmLinkErr && isKnownCode(mmCode);
      if (mmValid && !mmLinkErr && !isKnownCode(mmCode)) begin
        mmPend_r <= 1'b1;
      end else if (state_r != LR_EXALERT) begin
        mmPend_r <= 1'b0;
      end
    end
  end

  // alert port; a recovery exit takes the slot, message alert waits
  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      alertValid_r <= 1'b0;
      alertCode_r <= `LR_EXIT_OK;
      lastExit_r <= `LR_EXIT_OK;
    end else begin
      alertValid_r <= (state_r == LR_EXALERT) || mmPend_r;
      if (state_r == LR_EXALERT) begin
        alertCode_r <= exitPend_r;
      end else if (mmPend_r) begin
        alertCode_r <= `LR_ALERT_UNKNOWN_MM;
      end
      if ((state_r == LR_ENABLE && flagRx) || state_r == LR_EXFLAG) begin
        lastExit_r <= exitNxt;
      end
    end
  end

  assign linkResetSend = linkResetSend_r;
  assign txAbort = txAbort_r;
  assign checkState = checkState_r;
  assign portDisabled = portDisabled_r;
  assign portEnabled = portEnabled_r;
  assign portReady = portReady_r;
  assign portRestart = portRestart_r;
  assign operational = operational_r;
  assign privilegedMode = privMode_r;
  assign txBufferPointer = txPtr_r;
  assign txRetryPointer = retryPtr_r;
  assign outstanding = outstanding_r;
  assign bufDiscard = bufDiscard_r;
  assign alertValid = alertValid_r;
  assign alertCode = alertCode_r;
  assign lastExitCode = lastExit_r;
  assign mmAccept = mmAccept_r;

endmodule : lrec_exit_ctrl

/* testbench/lrec_exit_chk.sv */
`timescale 1ns/10ps
`include "lrec_cfg.svh"
module lrec_exit_chk
  import lrec_pkg::*;
(
  // clock and reset
  input wire logic mclk,
  input wire logic rst_b,
  // link and message inputs
  input wire logic txBusy,
  input wire logic codeViol,
  input wire logic disableCharRx,
  input wire logic flagRx,
  input wire logic mmValid,
  input wire logic mmLinkErr,
  input wire logic [`LR_CODE_W-1:0] mmCode,
  // port control and flags
  input wire logic txAbort,
  input wire logic checkState,
  input wire logic linkResetSend,
  input wire logic portDisabled,
  input wire logic portEnabled,
  input wire logic portReady,
  input wire logic portRestart,
  input wire logic operational,
  input wire logic privilegedMode,
  // alerts and messages
  input wire logic alertValid,
  input wire lrec_code_t alertCode,
  input wire lrec_code_t lastExitCode,
  input wire logic mmAccept
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_b);
  // exit steps after the usable flag drops, one per cycle
  sequence s_exit_tail;
    privilegedMode ##1 alertValid && alertCode == lastExitCode ##1 portRestart;
  endsequence
  // unknown code alert lands two cycles after the message
  sequence s_unknown_alert;
    ##2 alertValid && alertCode == `LR_ALERT_UNKNOWN_MM;
  endsequence
  property p_abort;
    codeViol && txBusy && portReady && !checkState |=> txAbort && checkState;
  endproperty
  a_abort: assert property (p_abort) else $error("abort missing");
  // margin of two cycles, though check level and send request change on the same edge
  property p_own_reset;
    $fell(checkState) |-> ##[0:2] linkResetSend;
  endproperty
  a_own_reset: assert property (p_own_reset) else $error("no reset");
  property p_enable;
    portDisabled && disableCharRx |=> portEnabled;
  endproperty
  a_enable: assert property (p_enable) else $error("not enabled");
  property p_ready;
    portEnabled && flagRx |=> portReady && lastExitCode == `LR_EXIT_OK;
  endproperty
  a_ready: assert property (p_ready) else $error("not ready");
  property p_exit;
    $fell(operational) |=> s_exit_tail;
  endproperty
  a_exit: assert property (p_exit) else $error("bad exit");
  property p_unknown;
    mmValid && !mmLinkErr && mmCode > `LR_MM_CODE_MAX |-> s_unknown_alert;
  endproperty
  a_unknown: assert property (p_unknown) else $error("no alert");
  property p_known;
    mmValid && !mmLinkErr && mmCode <= `LR_MM_CODE_MAX |=> mmAccept;
  endproperty
  a_known: assert property (p_known) else $error("not accepted");
  property p_linkerr;
    mmValid && mmLinkErr |=> !mmAccept ##1 !alertValid;
  endproperty
  a_linkerr: assert property (p_linkerr) else $error("bad frame");
endmodule : lrec_exit_chk

bind lrec_exit_ctrl lrec_exit_chk u_chk (
  .mclk, .rst_b, .txBusy, .codeViol, .disableCharRx, .flagRx, .mmValid,
  .mmLinkErr, .mmCode, .txAbort, .checkState, .linkResetSend, .portDisabled,
  .portEnabled, .portReady, .portRestart, .operational, .privilegedMode,
  .alertValid, .alertCode, .lastExitCode, .mmAccept
);

/* testbench/lrec_peer.sv */
`timescale 1ns/10ps
module lrec_peer #(
  parameter int DLY = 10
) (
  // clock
  input wire logic mclk,
  // local port stage as seen on the line
  input wire logic linkResetSend,
  input wire logic portDisabled,
  input wire logic portEnabled,
  // fault: 1 no flag, 2 no link reset, 3 no disable chars
  input wire logic [1:0] mode,
  // line events back to the port
  output logic linkResetRx = 1'b0,
  output logic linkResetTxDone = 1'b0,
  output logic disableCharRx = 1'b0,
  output logic flagRx = 1'b0
);
  logic [2:0] stage_r = 3'h0;
  int cnt_r = 0;
  // one delay counter, restarted whenever the port changes stage
  always_ff @(posedge mclk) begin
    stage_r <= {linkResetSend, portDisabled, portEnabled};
    if (stage_r != {linkResetSend, portDisabled, portEnabled}) begin
      cnt_r <= 0;
    end else if (cnt_r < 1000) begin
      cnt_r <= cnt_r + 1;
    end
    linkResetTxDone <= linkResetSend && cnt_r == DLY;
    linkResetRx <= linkResetSend && mode != 2'h2 && cnt_r == DLY - 2;
    // disable chars vanish once the port leaves the disabled state
    disableCharRx <= portDisabled && mode != 2'h3 && cnt_r >= DLY;
    flagRx <= portEnabled && mode != 2'h1 && cnt_r == DLY;
  end
endmodule : lrec_peer

/* testbench/link_recovery_exit_control_tb_top.sv */
`timescale 1ns/10ps
`include "lrec_cfg.svh"
module link_recovery_exit_control_tb_top;
  import lrec_pkg::*;
  logic mclk = 1'b0, rst_b = 1'b0, txBusy = 1'b0, codeViol = 1'b0;
  logic recoverReq = 1'b0, frameSent = 1'b0, ackRx = 1'b0, mmValid = 1'b0;
  logic mmLinkErr = 1'b0, cfgOperational = 1'b0, cfgNormalMode = 1'b0;
  logic [1:0] txFrameSequence = 2'h0, remoteRxSequence = 2'h0, mode = 2'h0;
  lrec_code_t mmCode = 8'h00, lastAlert = 8'h00, alertCode, lastExitCode;
  lrec_ptr_t txBufferPointer, txRetryPointer, outstanding;
  logic linkResetRx, linkResetTxDone, disableCharRx, flagRx, linkResetSend;
  logic txAbort, checkState, portDisabled, portEnabled, portReady, mmAccept;
  logic portRestart, operational, privilegedMode, bufDiscard, alertValid;
  int err_count = 0, cmp_count = 0, cycles = 0, alerts = 0, accepts = 0;
  int restarts = 0, discards = 0;
  // failure table: peer fault, peer sequence, exit code
  logic [1:0] md [4] = '{2'h0, 2'h1, 2'h2, 2'h3};
  logic [1:0] rx_frame_sequence [4] = '{2'h1, 2'h2, 2'h2, 2'h2};
  lrec_code_t ec [4] = '{`LR_EXIT_BAD_RETRY, `LR_EXIT_TO_READY,
    `LR_EXIT_LR_FAILED, `LR_EXIT_TO_DIS};
  // message table: code, link error, accepts, alerts
  lrec_code_t mc [4] = '{8'h3F, 8'h40, 8'hFF, 8'h00};
  logic me [4] = '{1'b0, 1'b0, 1'b1, 1'b0};
  lrec_code_t ma [4] = '{8'h01, 8'h00, 8'h00, 8'h01};
  lrec_code_t mal [4] = '{8'h00, 8'h01, 8'h00, 8'h00};

  always #2 mclk = ~mclk;

  // short deadline keeps timeout paths within a few dozen cycles
  lrec_exit_ctrl #(.DEADLINE_CYC(50)) DUT (.*);
  lrec_peer #(.DLY(10)) u_peer (.*);

  // tallies of single-cycle pulses, plus the hang guard
  always @(posedge mclk) begin
    cycles <= cycles + 1;
    alerts <= alerts + int'(alertValid === 1'b1);
    accepts <= accepts + int'(mmAccept === 1'b1);
    restarts <= restarts + int'(portRestart === 1'b1);
    discards <= discards + int'(bufDiscard === 1'b1);
    if (alertValid === 1'b1) lastAlert <= alertCode;
    if (cycles == 3000) begin
      err_count++;
      final_report();
    end
  end

  task automatic chk(input string nm, input lrec_code_t exp, got);
    cmp_count++;
    if (got !== exp) begin
      err_count++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk

  task automatic tick(input int n);
    repeat (n) @(posedge mclk);
  endtask : tick

  task automatic final_report;
    $display("comparisons %0d mismatches %0d", cmp_count, err_count);
    if (err_count == 0 && cmp_count > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : final_report

  initial begin
    int n, a;
    tick(6);
    rst_b <= 1'b1;
    tick(2);
    chk("portReady", 8'h01, portReady);
    frameSent <= 1'b1;
    tick(2);
    frameSent <= 1'b0;
    ackRx <= 1'b1;
    tick(1);
    ackRx <= 1'b0;
    tick(2);
    chk("txBufferPointer", 8'h02, txBufferPointer);
    chk("outstanding", 8'h01, outstanding);
    $display("test buffers done");
    // the ack above already retired one buffer, count only from here
    n = discards;
    txFrameSequence <= 2'h2;
    remoteRxSequence <= 2'h2;
    txBusy <= 1'b1;
    codeViol <= 1'b1;
    tick(1);
    codeViol <= 1'b0;
    tick(1);
    chk("txAbort", 8'h01, txAbort);
    chk("checkState", 8'h01, checkState);
    txBusy <= 1'b0;
    repeat (300) if (portReady !== 1'b1) @(posedge mclk);
    chk("portReady", 8'h01, portReady);
    chk("discards", 8'h01, lrec_code_t'(discards - n));
    chk("txRetryPointer", 8'h02, txRetryPointer);
    chk("lastExitCode", `LR_EXIT_OK, lastExitCode);
    $display("test recovery done");
    for (int i = 0; i < 4; i++) begin
      cfgOperational <= 1'b1;
      cfgNormalMode <= 1'b1;
      tick(1);
      cfgOperational <= 1'b0;
      cfgNormalMode <= 1'b0;
      mode <= md[i];
      remoteRxSequence <= rx_frame_sequence[i];
      recoverReq <= 1'b1;
      tick(1);
      recoverReq <= 1'b0;
      n = restarts;
      repeat (300) if (restarts == n) @(posedge mclk);
      chk("alertCode", ec[i], lastAlert);
      chk("lastExitCode", ec[i], lastExitCode);
      chk("operational", 8'h00, operational);
      chk("privilegedMode", 8'h01, privilegedMode);
    end
    mode <= 2'h0;
    $display("test exits done");
    for (int i = 0; i < 4; i++) begin
      n = alerts;
      a = accepts;
      mmCode <= mc[i];
      mmLinkErr <= me[i];
      mmValid <= 1'b1;
      tick(1);
      mmValid <= 1'b0;
      tick(4);
      chk("mmAccept", ma[i], lrec_code_t'(accepts - a));
      chk("alerts", mal[i], lrec_code_t'(alerts - n));
    end
    chk("alertCode", `LR_ALERT_UNKNOWN_MM, lastAlert);
    $display("test messages done");
    final_report();
  end
endmodule : link_recovery_exit_control_tb_top
